// file: rtl/dgp_gpio.sv
// Behaviour
// - Eight-pin second port, latch and direction
// - Direction one puts pin in input
// - Direction zero drives latch onto pin
// - Clear pull-up disable enables input-pin pull-ups
// - Output pins never get pull-ups
// - Option register resets to all ones
// - Enabled peripheral overrides pin direction
// - Only upper input pins detect changes
// - Port read latches snapshot for comparison
// - Mismatches ORed into one change flag
// - Change condition can wake from sleep
// - Mismatch keeps setting; read then clear
// - Second direction all ones; data held on soft reset
// - First direction ones, upper bits zero
// - Analog select field resets to zero
// - First port reads pins, writes latch
// - Lower first-port pins analog after power-on
`timescale 1ns/100ps
`default_nettype none

module dgp_gpio (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic soft_rst_i,
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic [4:0] pa_in_i,
  output logic [4:0] pa_out_o,
  output logic [4:0] pa_oe_o,
  input wire logic [7:0] pb_in_i,
  output logic [7:0] pb_out_o,
  output logic [7:0] pb_oe_o,
  output logic [7:0] pb_pullup_o,
  input wire logic [7:0] periph_en_i,
  input wire logic [7:0] periph_dir_i,
  output logic [2:0] analog_pin_select_o,
  output logic wake_o
);

  // Synchronised pin levels
  logic [4:0] pa_sync;
  logic [7:0] pb_sync;

  // Software-visible registers
  logic [4:0] first_port_data_reg;
  logic [7:0] second_port_data_reg;
  logic [4:0] first_port_direction_reg;
  logic [7:0] second_port_direction_reg;
  logic [2:0] analog_pin_select_reg;
  logic [7:0] timer_option_control_reg;
  logic chg_en_reg;

  // Change detector state
  logic [3:0] chg_snap;
  logic chg_mismatch;
  logic port_change_flag;

  // Address decode strobes
  logic wr_pa_data;
  logic wr_pb_data;
  logic wr_pa_dir;
  logic wr_pb_dir;
  logic wr_ana;
  logic wr_opt;
  logic wr_int;
  logic rd_pb_data;

  // Derived pin control
  logic [7:0] pb_dir_eff;
  logic [7:0] pb_pullup_next;
  logic [3:0] ana_mask;
  logic [4:0] pa_rd_val;
  logic [7:0] pb_rd_val;
  logic [7:0] int_rd_val;
  logic [7:0] rd_mux;
  logic [4:0] pa_oe_next;
  logic pullup_disable_n;

  // Pin synchronisers
  dgp_sync #(
    .W(dgp_pkg::PA_W)
  ) u_pa_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .async_i(pa_in_i),
    .sync_o(pa_sync)
  );

  dgp_sync #(
    .W(dgp_pkg::PB_W)
  ) u_pb_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .async_i(pb_in_i),
    .sync_o(pb_sync)
  );

  // Write strobes per register
  assign wr_pa_data = wr_i && (addr_i == dgp_pkg::ADDR_PA_DATA);
  assign wr_pb_data = wr_i && (addr_i == dgp_pkg::ADDR_PB_DATA);
  assign wr_pa_dir = wr_i && (addr_i == dgp_pkg::ADDR_PA_DIR);
  assign wr_pb_dir = wr_i && (addr_i == dgp_pkg::ADDR_PB_DIR);
  assign wr_ana = wr_i && (addr_i == dgp_pkg::ADDR_ANA_CFG);
  assign wr_opt = wr_i && (addr_i == dgp_pkg::ADDR_OPTION);
  assign wr_int = wr_i && (addr_i == dgp_pkg::ADDR_INT_CTRL);
  // Reading the second port is what re-arms the change snapshot
  assign rd_pb_data = rd_i && (addr_i == dgp_pkg::ADDR_PB_DATA);

  // Pull-ups enabled by the active-low bit
  assign pullup_disable_n = timer_option_control_reg[dgp_pkg::OPT_PULLUP_DIS_BIT];

  // Per-pin direction override and pull-up gating
  genvar gi;
  generate
    for (gi = 0; gi < dgp_pkg::PB_W; gi++) begin : g_pb_pin
      // Peripheral wins while enabled
      assign pb_dir_eff[gi] = periph_en_i[gi] ? periph_dir_i[gi] : second_port_direction_reg[gi];
      // Pull-up only on input pins and when globally enabled
      assign pb_pullup_next[gi] = !pullup_disable_n && pb_dir_eff[gi];
    end
  endgenerate

  // Analog pins per select code; higher codes free more pins as digital
  assign ana_mask = dgp_pkg::ANA_ALL_MASK >> analog_pin_select_reg;

  // Analog pins read as zero, upper bits unimplemented
  assign pa_rd_val = pa_sync & ~{1'b0, ana_mask};
  assign pb_rd_val = pb_sync;

  // Interrupt control readback
  assign int_rd_val = {4'h0, chg_en_reg, 2'h0, port_change_flag};

  // Open-drain top pin only pulls low
  assign pa_oe_next = {~first_port_direction_reg[dgp_pkg::PA_OD_BIT]
                       & ~first_port_data_reg[dgp_pkg::PA_OD_BIT],
                       ~first_port_direction_reg[3:0]};

  // Read mux; direction readback shows overrides, unmapped reads zero
  always_comb begin
    case (addr_i)
      dgp_pkg::ADDR_PA_DATA: rd_mux = {3'h0, pa_rd_val};
      dgp_pkg::ADDR_PB_DATA: rd_mux = pb_rd_val;
      dgp_pkg::ADDR_PA_DIR: rd_mux = {3'h0, first_port_direction_reg};
      dgp_pkg::ADDR_PB_DIR: rd_mux = pb_dir_eff;
      dgp_pkg::ADDR_ANA_CFG: rd_mux = {5'h00, analog_pin_select_reg};
      dgp_pkg::ADDR_OPTION: rd_mux = timer_option_control_reg;
      dgp_pkg::ADDR_INT_CTRL: rd_mux = int_rd_val;
      default: rd_mux = dgp_pkg::RD_ZERO;
    endcase
  end

  // Change detection on the upper four pins
  dgp_change_det u_chg (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .pins_i(pb_sync[7:4]),
    .is_input_i(pb_dir_eff[7:4]),
    .snap_i(rd_pb_data),
    .flag_wr_i(wr_int),
    .flag_wdata_i(wdata_i[dgp_pkg::INT_FLAG_BIT]),
    .snap_o(chg_snap),
    .mismatch_o(chg_mismatch),
    .flag_o(port_change_flag)
  );

  // Output latches; cleared at power-on, kept on soft resets
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      first_port_data_reg <= dgp_pkg::PA_DATA_POR;
      second_port_data_reg <= dgp_pkg::PB_DATA_POR;
    end else begin
      if (wr_pa_data) begin
        first_port_data_reg <= wdata_i[4:0];
      end
      if (wr_pb_data) begin
        second_port_data_reg <= wdata_i;
      end
    end
  end

  // Configuration registers; every reset restores them
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      first_port_direction_reg <= dgp_pkg::PA_DIR_RST;
      second_port_direction_reg <= dgp_pkg::PB_DIR_RST;
      analog_pin_select_reg <= dgp_pkg::ANA_CFG_RST;
      timer_option_control_reg <= dgp_pkg::OPTION_RST;
      chg_en_reg <= 1'b0;
    end else if (soft_rst_i) begin
      // Soft reset beats a same-cycle write
      first_port_direction_reg <= dgp_pkg::PA_DIR_RST;
      second_port_direction_reg <= dgp_pkg::PB_DIR_RST;
      analog_pin_select_reg <= dgp_pkg::ANA_CFG_RST;
      timer_option_control_reg <= dgp_pkg::OPTION_RST;
      chg_en_reg <= 1'b0;
    end else begin
      if (wr_pa_dir) begin
        first_port_direction_reg <= wdata_i[4:0];
      end
      if (wr_pb_dir) begin
        second_port_direction_reg <= wdata_i;
      end
      if (wr_ana) begin
        analog_pin_select_reg <= wdata_i[2:0];
      end
      if (wr_opt) begin
        timer_option_control_reg <= wdata_i;
      end
      if (wr_int) begin
        chg_en_reg <= wdata_i[dgp_pkg::INT_CHG_EN_BIT];
      end
    end
  end

  // Registered pin drive; pins stay released during reset
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pa_out_o <= 5'h00;
      pa_oe_o <= 5'h00;
      pb_out_o <= 8'h00;
      pb_oe_o <= 8'h00;
      pb_pullup_o <= 8'h00;
    end else begin
      // Open-drain bit never drives high
      pa_out_o <= first_port_data_reg & {1'b0, 4'hF};
      pa_oe_o <= pa_oe_next;
      pb_out_o <= second_port_data_reg;
      pb_oe_o <= ~pb_dir_eff;
      pb_pullup_o <= pb_pullup_next;
    end
  end

  // Read data and status outputs
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= dgp_pkg::RD_ZERO;
      analog_pin_select_o <= dgp_pkg::ANA_CFG_RST;
      wake_o <= 1'b0;
    end else begin
      // Data valid only the cycle after the strobe
      rdata_o <= rd_i ? rd_mux : dgp_pkg::RD_ZERO;
      analog_pin_select_o <= analog_pin_select_reg;
      wake_o <= port_change_flag && chg_en_reg;
    end
  end

  // Checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  a_pb_dir_input: assert property (pb_oe_o == ~$past(pb_dir_eff))
    else $error("second port enable does not follow direction");

  a_pb_drive_latch: assert property (wr_pb_data |-> ##2 pb_out_o == $past(wdata_i, 2))
    else $error("second port pins do not drive written latch");

  // With pull-ups on, every pin is either pulled up or driven
  a_pullup_global: assert property (!pullup_disable_n |=> (pb_pullup_o | pb_oe_o) == 8'hFF)
    else $error("pull-ups missing while enabled");

  a_pullup_outputs: assert property ((pb_pullup_o & pb_oe_o) == 8'h00)
    else $error("pull-up on a driven pin");

  a_soft_reset_vals: assert property (
    soft_rst_i |=> (timer_option_control_reg == 8'hFF
    && second_port_direction_reg == 8'hFF && first_port_direction_reg == 5'h1F
    && analog_pin_select_reg == 3'h0))
    else $error("soft reset values wrong");

  a_periph_override: assert property (
    ((pb_oe_o ^ ~$past(periph_dir_i)) & $past(periph_en_i)) == 8'h00)
    else $error("peripheral override ignored");

  a_out_pins_quiet: assert property (
    (pb_dir_eff[7:4] == 4'h0) |=> !$past(chg_mismatch))
    else $error("output pin took part in change detection");

  a_snap_on_read: assert property (rd_pb_data |=> chg_snap == $past(pb_sync[7:4]))
    else $error("snapshot not taken on port read");

  a_flag_sets: assert property (chg_mismatch |=> port_change_flag)
    else $error("mismatch did not set change flag");

  a_wake_req: assert property (
    (port_change_flag && chg_en_reg) |=> wake_o)
    else $error("change flag did not request wake");

  // Wake drops once the flag is gone
  a_wake_clear: assert property (!port_change_flag |=> !wake_o)
    else $error("wake held without change flag");

  a_pa_write: assert property (wr_pa_data |=> first_port_data_reg == $past(wdata_i[4:0]))
    else $error("first port latch not written");

  a_pa_analog_read: assert property (
    (rd_i && addr_i == dgp_pkg::ADDR_PA_DATA && analog_pin_select_reg == 3'h0)
    |=> rdata_o[7:0] == {3'h0, $past(pa_sync[4]), 4'h0})
    else $error("analog first port pins not reading zero");

  a_pb_read: assert property (rd_pb_data |=> rdata_o == $past(pb_sync))
    else $error("second port read wrong");

  // Lower four first-port pins drive per their direction bits
  a_pa_dir_drive: assert property (
    pa_oe_o[3:0] == ~$past(first_port_direction_reg[3:0]))
    else $error("first port enable does not follow direction");

  a_pa_open_drain: assert property (!pa_out_o[dgp_pkg::PA_OD_BIT])
    else $error("open-drain pin driven high");

  // Read data stand for one cycle only
  a_rdata_one_cycle: assert property (!rd_i |=> rdata_o == dgp_pkg::RD_ZERO)
    else $error("read data outside the read cycle");

  // A clear lands when no mismatch competes with it
  a_flag_clear: assert property (
    (wr_int && !wdata_i[dgp_pkg::INT_FLAG_BIT] && !chg_mismatch) |=> !port_change_flag)
    else $error("change flag clear ignored");

  // Unimplemented first-port direction bits read zero
  a_pa_dir_upper: assert property (
    (rd_i && addr_i == dgp_pkg::ADDR_PA_DIR) |=> rdata_o[7:5] == 3'h0)
    else $error("unimplemented direction bits not zero");

  // Main scenarios reached
  c_flag_set: cover property (chg_mismatch ##1 port_change_flag);
  c_clear_after_read: cover property (rd_pb_data ##1 wr_int ##1 !port_change_flag);
  c_wake: cover property (wake_o);
  c_override: cover property (|periph_en_i);
  c_pullup_on: cover property (|pb_pullup_o);

endmodule : dgp_gpio

`default_nettype wire

// file: rtl/dgp_pkg.sv
package dgp_pkg;

  // Bus widths
  localparam int unsigned ADDR_W = 3;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned PA_W = 5;
  localparam int unsigned PB_W = 8;
  localparam int unsigned ANA_W = 3;
  localparam int unsigned CHG_W = 4;
  localparam int unsigned ANA_PINS = 4;

  // Register word addresses
  localparam logic [2:0] ADDR_PA_DATA = 3'h0;
  localparam logic [2:0] ADDR_PB_DATA = 3'h1;
  localparam logic [2:0] ADDR_PA_DIR = 3'h2;
  localparam logic [2:0] ADDR_PB_DIR = 3'h3;
  localparam logic [2:0] ADDR_ANA_CFG = 3'h4;
  localparam logic [2:0] ADDR_OPTION = 3'h5;
  localparam logic [2:0] ADDR_INT_CTRL = 3'h6;

  // Field positions
  localparam int unsigned OPT_PULLUP_DIS_BIT = 7;
  localparam int unsigned INT_FLAG_BIT = 0;
  localparam int unsigned INT_CHG_EN_BIT = 3;
  localparam int unsigned PA_OD_BIT = 4;
  localparam int unsigned CHG_LSB = 4;

  // Reset values
  localparam logic [4:0] PA_DIR_RST = 5'h1F;
  localparam logic [7:0] PB_DIR_RST = 8'hFF;
  localparam logic [7:0] OPTION_RST = 8'hFF;
  localparam logic [2:0] ANA_CFG_RST = 3'h0;
  localparam logic [4:0] PA_DATA_POR = 5'h00;
  localparam logic [7:0] PB_DATA_POR = 8'h00;
  localparam logic [3:0] ANA_ALL_MASK = 4'hF;
  localparam logic [7:0] RD_ZERO = 8'h00;

endpackage : dgp_pkg

// file: rtl/dgp_sync.sv
`timescale 1ns/100ps
`default_nettype none

// Two-stage synchroniser for asynchronous pin levels
module dgp_sync #(
  parameter int unsigned W = 8
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);

  // First stage, read only by the second stage
  logic [W-1:0] meta_reg;

  // Both stages clear to zero, reset takes constants only
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_reg <= '0;
      sync_o <= '0;
    end else begin
      meta_reg <= async_i;
      sync_o <= meta_reg;
    end
  end

endmodule : dgp_sync

`default_nettype wire

// file: rtl/dgp_change_det.sv
`timescale 1ns/100ps
`default_nettype none

// Change detector on the upper second-port pins
module dgp_change_det (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [3:0] pins_i,
  input wire logic [3:0] is_input_i,
  input wire logic snap_i,
  input wire logic flag_wr_i,
  input wire logic flag_wdata_i,
  output logic [3:0] snap_o,
  output logic mismatch_o,
  output logic flag_o
);

  // Per-pin mismatch, outputs masked out
  logic [3:0] diff;
  logic flag_next;

  assign diff = (pins_i ^ snap_o) & is_input_i;
  assign mismatch_o = |diff;
  // Set beats a same-cycle clear, so a live change is never dropped
  assign flag_next = mismatch_o | (flag_wr_i ? flag_wdata_i : flag_o);

  // Snapshot follows every port read; flag keeps its value on soft resets
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      snap_o <= 4'h0;
      flag_o <= 1'b0;
    end else begin
      if (snap_i) begin
        snap_o <= pins_i;
      end
      flag_o <= flag_next;
    end
  end

endmodule : dgp_change_det

`default_nettype wire

// file: verification/dgp_pin_model.sv
`timescale 1ns/100ps
`default_nettype none

// Far side of the second port: resolves each pin from every party
module dgp_pin_model (
  input wire logic clk_i,
  input wire logic [7:0] drv_i,
  input wire logic [7:0] oe_i,
  input wire logic [7:0] pullup_i,
  input wire logic [7:0] ext_i,
  input wire logic [7:0] ext_en_i,
  output logic [7:0] level_o
);
  // Undriven pins show the inverse of their last level, so a stale value never reads as good
  logic [7:0] float_reg = 8'h55;

  // Inverse of the level each pin showed last cycle
  always @(posedge clk_i) begin
    float_reg <= ~level_o;
  end

  // Device driver wins, then the outside driver, then the pull-up
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (oe_i[i]) level_o[i] = drv_i[i];
      else if (ext_en_i[i]) level_o[i] = ext_i[i];
      else if (pullup_i[i]) level_o[i] = 1'b1;
      else level_o[i] = float_reg[i];
    end
  end
endmodule : dgp_pin_model

`default_nettype wire

// file: verification/testbench.sv
`timescale 1ns/100ps
`default_nettype none

module testbench;
  logic clk_i, rst_n_i, soft_rst_i, wr_i, rd_i, wake_o;
  logic [2:0] addr_i, ana;
  logic [7:0] wdata_i, rdata_o, pb_out_o, pb_oe_o, pb_pullup_o, pb_lvl;
  logic [7:0] periph_en_i, periph_dir_i, ext, ext_en;
  logic [4:0] pa_in_i, pa_out_o, pa_oe_o;
  int errors, checked, cycles;
  logic [31:0] seed;
  // Reference copy of every register, by word address
  int r[8];

  dgp_gpio DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .soft_rst_i(soft_rst_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .pa_in_i(pa_in_i), .pa_out_o(pa_out_o), .pa_oe_o(pa_oe_o), .pb_in_i(pb_lvl),
    .pb_out_o(pb_out_o), .pb_oe_o(pb_oe_o), .pb_pullup_o(pb_pullup_o),
    .periph_en_i(periph_en_i), .periph_dir_i(periph_dir_i),
    .analog_pin_select_o(ana), .wake_o(wake_o));

  dgp_pin_model PINS (.clk_i(clk_i), .drv_i(pb_out_o), .oe_i(pb_oe_o),
    .pullup_i(pb_pullup_o), .ext_i(ext), .ext_en_i(ext_en), .level_o(pb_lvl));

  // 250 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  // Hang guard, well above the few hundred cycles the run needs
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      end_of_test();
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // Direction after peripheral override
  function automatic logic [7:0] eff_dir();
    return (8'(r[3]) & ~periph_en_i) | (periph_dir_i & periph_en_i);
  endfunction : eff_dir

  // Expected pin levels while the outside drives every input pin
  function automatic logic [7:0] lvl();
    return (8'(r[1]) & ~eff_dir()) | (ext & eff_dir());
  endfunction : lvl

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    r[a] = d;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 check(rdata_o, exp);
  endtask : rd

  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : idle

  task automatic end_of_test();
    if (errors == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test

  initial begin
    {rst_n_i, soft_rst_i, wr_i, rd_i, addr_i, wdata_i} = '0;
    {periph_en_i, periph_dir_i, ext} = '0;
    ext_en = 8'hFF;
    seed = 32'h5327B82A;
    pa_in_i = seed[4:0];
    r = '{0, 0, 'h1F, 'hFF, 0, 'hFF, 0, 0};
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    idle(1);
    check(pb_pullup_o, 8'h00);
    check(pb_oe_o, 8'h00);
    rd(3'h2, 8'h1F);
    rd(3'h3, 8'hFF);
    rd(3'h4, 8'h00);
    rd(3'h5, 8'hFF);
    rd(3'h7, 8'h00);
    rd(3'h0, {3'h0, pa_in_i[4], 4'h0});
    // First port: digital pins read back, latch drives outputs
    wr(3'h4, 8'h07);
    idle(1);
    check({5'h0, ana}, 8'h07);
    rd(3'h0, {3'h0, pa_in_i});
    wr(3'h2, 8'h00);
    wr(3'h0, 8'h0F);
    idle(2);
    check({3'h0, pa_out_o}, 8'h0F);
    check({3'h0, pa_oe_o}, 8'h1F);
    // Two lowest pins analog, the rest read back
    wr(3'h4, 8'h02);
    rd(3'h0, {3'h0, pa_in_i[4:2], 2'h0});
    // Random latch, direction and pin levels; whole-value writes only
    for (int k = 0; k < 8; k++) begin
      seed = lfsr(seed);
      ext <= seed[7:0];
      wr(3'h1, seed[15:8]);
      wr(3'h3, seed[23:16]);
      idle(4);
      check(pb_out_o, 8'(r[1]));
      check(pb_oe_o, ~eff_dir());
      rd(3'h1, lvl());
      rd(3'h3, eff_dir());
    end
    // Pull-ups on input pins only; outside lets go, pull-up reads high
    ext <= 8'hFF;
    ext_en <= 8'h00;
    wr(3'h5, 8'h7F);
    idle(4);
    check(pb_pullup_o, eff_dir());
    rd(3'h1, lvl());
    ext_en <= 8'hFF;
    // Peripheral takes over the upper pins
    @(posedge clk_i);
    periph_en_i <= 8'hF0;
    periph_dir_i <= 8'hA0;
    idle(2);
    check(pb_oe_o, ~eff_dir());
    rd(3'h3, eff_dir());
    // Other reset: configuration back to defaults, latches kept
    @(posedge clk_i);
    periph_en_i <= 8'h00;
    soft_rst_i <= 1'b1;
    @(posedge clk_i);
    soft_rst_i <= 1'b0;
    r[2] = 'h1F;
    r[3] = 'hFF;
    r[4] = 0;
    r[5] = 'hFF;
    idle(2);
    rd(3'h3, 8'hFF);
    rd(3'h5, 8'hFF);
    rd(3'h4, 8'h00);
    check(pb_out_o, 8'(r[1]));
    // Change detection: snapshot, clear, then a pin moves
    ext <= 8'h00;
    idle(4);
    rd(3'h1, lvl());
    wr(3'h6, 8'h08);
    rd(3'h6, 8'h08);
    ext <= 8'h20;
    idle(6);
    check({7'h0, wake_o}, 8'h01);
    rd(3'h6, 8'h09);
    wr(3'h6, 8'h08);
    rd(3'h6, 8'h09);
    rd(3'h1, 8'h20);
    wr(3'h6, 8'h08);
    rd(3'h6, 8'h08);
    check({7'h0, wake_o}, 8'h00);
    // Upper pins as outputs and lower pins stay out of the comparison
    wr(3'h1, 8'h80);
    wr(3'h3, 8'h0F);
    ext <= 8'h21;
    idle(6);
    rd(3'h6, 8'h08);
    end_of_test();
  end
endmodule : testbench

`default_nettype wire
